// [verilog/tcml_top.sv]
// Channel mode logic: AXI4-Lite registers, compare reference, buffering, filter
// ---------------------------------------------------------------
// Overview of operation
// RULE1 - Mode field 14:12 drives the reference only while channel is output
// RULE2 - Reference is active high; pin level flipped by polarity select
// RULE3 - Mode 000 frozen: match leaves reference unchanged
// RULE4 - Mode 001 sets reference high on counter match
// RULE5 - Mode 010 drives reference low on counter match
// RULE6 - Mode 011 toggles reference on every counter match
// RULE7 - Mode 100 forces reference inactive, 101 forces active
// RULE8 - PWM1: up active below compare; down inactive above compare
// RULE9 - PWM2: up inactive below compare; down active above compare
// RULE10 - PWM level changes only with comparison or frozen-to-PWM switch
// RULE11 - Buffer off: compare write reaches shadow at once
// RULE12 - Buffer on: access hits buffer, copied to shadow each update
// RULE13 - Software uses PWM without buffer only in one-pulse operation
// RULE14 - Fast off: trigger has no direct effect, at least five cycles
// RULE15 - Fast on: trigger edge acts as compare match; the code ignores the trigger in PWM modes 110 and 111
// RULE16 - Filter field 15:12 applies only while channel is input
// RULE17 - Filter output changes after N equal consecutive samples
// RULE18 - Codes 0000-0011 sample at clock: none, 2, 4, 8
// RULE19 - Codes 0100-1001 sample at clock/2,/4,/8, six then eight
// RULE20 - Codes 1010-1100 at clock/16 N 5,6,8; 1101-1110 clock/32 N 5,6
// RULE21 - Code 1111 samples at clock/32 with eight samples
// RULE22 - Direction 00 means output, any other value means input
// RULE23 - Filter sampling uses a one-cycle enable tick from a divider
// ---------------------------------------------------------------
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tcml_top (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  // AXI4-Lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Timer side
  input  wire logic [15:0] COUNT_VALUE,
  input  wire logic        COUNT_DOWN,
  input  wire logic        UPDATE_EVENT,
  input  wire logic        TRIG_EDGE,
  input  wire logic        TIMER_INPUT_B,
  output logic             CMP_REFERENCE,
  output logic             CMP_OUTPUT_PIN,
  output logic             FILTERED_INPUT_B
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic [15:0] mode_reg;
  logic [15:0] buf_reg;
  logic [15:0] shadow_reg;
  logic [1:0]  ctrl_reg;
  logic        ref_reg;
  logic        pin_reg;
  logic        sync1_reg;
  logic        sync2_reg;
  logic        ref_next;
  logic        filt_out;

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  // ---------------------------------------------------------------
  // Write channel decode
  // ---------------------------------------------------------------
  // Address and data are held separately so either may arrive first
  wire logic wr_go   = aw_full_reg && w_full_reg && !bvalid_reg;
  wire logic aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire logic w_take  = S_AXI_WVALID && S_AXI_WREADY;
  wire logic wr_mode = wr_go && aw_addr_reg == tcml_pkg::OFS_MODE;
  wire logic wr_cmp  = wr_go && aw_addr_reg == tcml_pkg::OFS_CMP;
  wire logic wr_ctrl = wr_go && aw_addr_reg == tcml_pkg::OFS_CTRL;
  wire logic wr_ro   = aw_addr_reg == tcml_pkg::OFS_STAT ||
                       aw_addr_reg == tcml_pkg::OFS_SHADOW;
  wire logic wr_hit  = wr_mode || wr_cmp || wr_ctrl || wr_ro;

  wire logic [31:0] mode_wval = merge({16'h0000, mode_reg}, wdata_reg, wstrb_reg);
  wire logic [31:0] cmp_wval  = merge({16'h0000, buf_reg}, wdata_reg, wstrb_reg);
  wire logic [31:0] ctrl_wval = merge({30'h0, ctrl_reg}, wdata_reg, wstrb_reg);

  // Readies drop with CE so no beat is accepted while state is frozen
  assign S_AXI_AWREADY = CE && !aw_full_reg;
  assign S_AXI_WREADY  = CE && !w_full_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;

  // Write handshake state
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= tcml_pkg::RESP_OKAY;
    end else if (CE) begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? tcml_pkg::RESP_OKAY : tcml_pkg::RESP_SLV;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  wire logic        rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire logic [31:0] stat_val = {29'h0, pin_reg, filt_out, ref_reg};
  wire logic        rd_m = S_AXI_ARADDR == tcml_pkg::OFS_MODE;
  wire logic        rd_c = S_AXI_ARADDR == tcml_pkg::OFS_CMP;
  wire logic        rd_k = S_AXI_ARADDR == tcml_pkg::OFS_CTRL;
  wire logic        rd_s = S_AXI_ARADDR == tcml_pkg::OFS_STAT;
  wire logic        rd_h = S_AXI_ARADDR == tcml_pkg::OFS_SHADOW;
  wire logic        rd_hit = rd_m || rd_c || rd_k || rd_s || rd_h;
  // Compare offset shows the buffer; with buffering off it equals the shadow
  wire logic [31:0] rd_data = rd_m ? {16'h0000, mode_reg} :
                              rd_c ? {16'h0000, buf_reg} :      // [RULE12]
                              rd_k ? {30'h0, ctrl_reg} :
                              rd_s ? stat_val :
                              rd_h ? {16'h0000, shadow_reg} : 32'h0000_0000;

  assign S_AXI_ARREADY = CE && !rvalid_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;

  // Read answer register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= tcml_pkg::RESP_OKAY;
    end else if (CE) begin
      if (rd_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_data;
        rresp_reg  <= rd_hit ? tcml_pkg::RESP_OKAY : tcml_pkg::RESP_SLV;
      end else if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration fields
  // ---------------------------------------------------------------
  wire tcml_pkg::tcml_ocmode_e mode = tcml_pkg::tcml_ocmode_e'(mode_reg[tcml_pkg::MODE_LSB +: 3]);
  wire logic       is_out  = mode_reg[tcml_pkg::DIR_LSB +: 2] == tcml_pkg::DIR_OUT; // [RULE22]
  wire logic       buf_en  = mode_reg[tcml_pkg::BUF_BIT];
  wire logic       fast_en = mode_reg[tcml_pkg::FAST_BIT];
  wire logic [3:0] filt_sel = mode_reg[tcml_pkg::FILT_LSB +: 4];
  wire logic       pol     = ctrl_reg[tcml_pkg::POL_BIT];

  // Shadow loads directly when unbuffered, else from the buffer on update
  wire logic [15:0] shadow_next =
    (wr_cmp && !buf_en)       ? cmp_wval[15:0] :                   // [RULE11]
    (buf_en && UPDATE_EVENT)  ? buf_reg : shadow_reg;              // [RULE12]

  // Register file
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_reg   <= tcml_pkg::RST_MODE;
      buf_reg    <= tcml_pkg::RST_CMP;
      shadow_reg <= tcml_pkg::RST_CMP;
      ctrl_reg   <= tcml_pkg::RST_CTRL;
    end else if (CE) begin
      if (wr_mode) mode_reg <= mode_wval[15:0];
      if (wr_cmp)  buf_reg  <= cmp_wval[15:0];
      if (wr_ctrl) ctrl_reg <= ctrl_wval[1:0];
      shadow_reg <= shadow_next;
    end
  end

  // ---------------------------------------------------------------
  // Compare reference
  // ---------------------------------------------------------------
  wire logic match = COUNT_VALUE == shadow_reg;
  wire logic lt    = COUNT_VALUE < shadow_reg;
  wire logic gt    = COUNT_VALUE > shadow_reg;
  // Trigger only counts as a match in fast mode; otherwise the counter
  // path alone moves the reference, which costs the trigger several cycles
  wire logic hit   = match || (fast_en && TRIG_EDGE);              // [RULE14] [RULE15]
  // PWM level is a pure function of the compare, so it moves only with it
  wire logic pwm1  = COUNT_DOWN ? !gt : lt;                        // [RULE8] [RULE10]
  wire logic pwm2  = COUNT_DOWN ? gt : !lt;                        // [RULE9] [RULE10]

  // Next reference level by mode; input channels hold it
  always_comb begin
    ref_next = ref_reg;
    if (is_out) begin                                              // [RULE1]
      case (mode)
        tcml_pkg::OCM_FROZEN: ref_next = ref_reg;                  // [RULE3]
        tcml_pkg::OCM_SET:    ref_next = hit ? 1'b1 : ref_reg;     // [RULE4]
        tcml_pkg::OCM_CLR:    ref_next = hit ? 1'b0 : ref_reg;     // [RULE5]
        tcml_pkg::OCM_TOGGLE: ref_next = hit ? !ref_reg : ref_reg; // [RULE6]
        tcml_pkg::OCM_FORCE0: ref_next = 1'b0;                     // [RULE7]
        tcml_pkg::OCM_FORCE1: ref_next = 1'b1;                     // [RULE7]
        tcml_pkg::OCM_PWM1:   ref_next = pwm1;
        tcml_pkg::OCM_PWM2:   ref_next = pwm2;
        default:              ref_next = ref_reg;
      endcase
    end
  end

  // Reference and pin flops; the pin is the reference seen through polarity
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ref_reg <= 1'b0;
      pin_reg <= 1'b0;
    end else if (CE) begin
      ref_reg <= ref_next;
      pin_reg <= ref_next ^ pol;                                   // [RULE2]
    end
  end

  assign CMP_REFERENCE  = ref_reg;
  assign CMP_OUTPUT_PIN = pin_reg;

  // ---------------------------------------------------------------
  // Input path
  // ---------------------------------------------------------------
  // Two-stage synchroniser for the asynchronous pin
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (CE) begin
      sync1_reg <= TIMER_INPUT_B;
      sync2_reg <= sync1_reg;
    end
  end

  tcml_filt u_filt (
    .clk    (CLK),
    .arst_n (ARST_N),
    .ce     (CE),
    .en     (!is_out),                                             // [RULE16]
    .code   (filt_sel),
    .din    (sync2_reg),
    .dout   (filt_out)
  );

  assign FILTERED_INPUT_B = filt_out;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  AST_IN_HOLD: assert property (CE && !is_out |=> $stable(CMP_REFERENCE)) // [RULE1]
    else $error("reference moved while channel is an input");
  AST_PIN_POL: assert property (CE |=> CMP_OUTPUT_PIN == (CMP_REFERENCE ^ $past(pol))) // [RULE2]
    else $error("pin level does not follow reference and polarity");
  AST_FROZEN: assert property (CE && is_out && mode == tcml_pkg::OCM_FROZEN // [RULE3]
    |=> $stable(CMP_REFERENCE))
    else $error("frozen mode changed the reference");
  AST_SET: assert property (CE && is_out && mode == tcml_pkg::OCM_SET && match // [RULE4]
    |=> CMP_REFERENCE)
    else $error("set-on-match did not drive reference high");
  AST_CLR: assert property (CE && is_out && mode == tcml_pkg::OCM_CLR && match // [RULE5]
    |=> !CMP_REFERENCE)
    else $error("clear-on-match did not drive reference low");
  AST_TOGGLE: assert property (CE && is_out && mode == tcml_pkg::OCM_TOGGLE && match // [RULE6]
    |=> CMP_REFERENCE != $past(CMP_REFERENCE))
    else $error("toggle mode did not invert on match");
  AST_FORCE: assert property (CE && is_out && mode == tcml_pkg::OCM_FORCE1 // [RULE7]
    |=> CMP_REFERENCE ##0 CMP_OUTPUT_PIN != $past(pol))
    else $error("forced-active mode not active");
  AST_PWM1_UP: assert property (CE && is_out && mode == tcml_pkg::OCM_PWM1 && !COUNT_DOWN // [RULE8]
    |=> CMP_REFERENCE == $past(COUNT_VALUE < shadow_reg))
    else $error("PWM1 up-count level wrong");
  AST_PWM2_DN: assert property (CE && is_out && mode == tcml_pkg::OCM_PWM2 && COUNT_DOWN // [RULE9]
    |=> CMP_REFERENCE == $past(COUNT_VALUE > shadow_reg))
    else $error("PWM2 down-count level wrong");
  AST_BUF_OFF: assert property (CE && wr_cmp && !buf_en // [RULE11]
    |=> shadow_reg == $past(cmp_wval[15:0]))
    else $error("unbuffered compare write missed the shadow");
  AST_BUF_ON: assert property (CE && buf_en && UPDATE_EVENT // [RULE12]
    |=> shadow_reg == $past(buf_reg))
    else $error("update event did not copy buffer to shadow");
  AST_NO_FAST: assert property (CE && is_out && !fast_en && mode == tcml_pkg::OCM_SET // [RULE14]
    && !match && !CMP_REFERENCE |=> !CMP_REFERENCE)
    else $error("trigger acted without fast enable");
  AST_FAST: assert property (CE && is_out && fast_en && TRIG_EDGE // [RULE15]
    && mode == tcml_pkg::OCM_SET |=> CMP_REFERENCE)
    else $error("fast trigger did not act as a match");

  CVR_TOGGLE: cover property (is_out && mode == tcml_pkg::OCM_TOGGLE && match ##1
                              $changed(CMP_REFERENCE));
  CVR_PWM: cover property (is_out && mode == tcml_pkg::OCM_PWM1 && $rose(CMP_REFERENCE));
  CVR_UPDATE: cover property (buf_en && UPDATE_EVENT && buf_reg != shadow_reg);
  CVR_FAST: cover property (fast_en && TRIG_EDGE && !match && is_out);

endmodule : tcml_top
`default_nettype wire

// [verilog/tcml_pkg.sv]
// Package: register map, field layout, reset values and mode codes of the channel
package tcml_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ADDR_W = 8;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE   = 8'h00; // capture_compare_mode_one
  localparam logic [7:0] OFS_CMP    = 8'h04; // ch_compare_value (buffer side)
  localparam logic [7:0] OFS_CTRL   = 8'h08; // polarity and one-pulse select
  localparam logic [7:0] OFS_STAT   = 8'h0C; // live channel state, read only
  localparam logic [7:0] OFS_SHADOW = 8'h10; // active compare value, read only

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned MODE_LSB   = 12; // out_cmp_mode, 3 bits
  localparam int unsigned FILT_LSB   = 12; // input_filter_sel, 4 bits
  localparam int unsigned FAST_BIT   = 11; // cmp_fast_en
  localparam int unsigned BUF_BIT    = 10; // cmp_buffer_en
  localparam int unsigned DIR_LSB    = 8;  // channel_dir_sel, 2 bits
  localparam int unsigned POL_BIT    = 0;  // output_polarity_sel
  localparam int unsigned OPM_BIT    = 1;  // one_pulse_sel
  localparam int unsigned ST_REF_BIT = 0;
  localparam int unsigned ST_FLT_BIT = 1;
  localparam int unsigned ST_PIN_BIT = 2;

  // ---------------------------------------------------------------
  // Reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_MODE  = 16'h0000;
  localparam logic [15:0] RST_CMP   = 16'h0000;
  localparam logic [1:0]  RST_CTRL  = 2'h0;
  localparam logic [1:0]  DIR_OUT   = 2'h0;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;

  // Divider shift per filter code, code 15 first
  localparam logic [15:0][2:0] FILT_SH = {3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3,
                                          3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
  // Consecutive samples per filter code, code 15 first; 1 means no filtering
  localparam logic [15:0][3:0] FILT_N = {4'h8, 4'h6, 4'h5, 4'h8, 4'h6, 4'h5, 4'h8, 4'h6,
                                         4'h8, 4'h6, 4'h8, 4'h6, 4'h8, 4'h4, 4'h2, 4'h1};

  // Output compare modes
  typedef enum logic [2:0] {
    OCM_FROZEN = 3'h0,
    OCM_SET    = 3'h1,
    OCM_CLR    = 3'h2,
    OCM_TOGGLE = 3'h3,
    OCM_FORCE0 = 3'h4,
    OCM_FORCE1 = 3'h5,
    OCM_PWM1   = 3'h6,
    OCM_PWM2   = 3'h7
  } tcml_ocmode_e;

endpackage : tcml_pkg

// [verilog/tcml_filt.sv]
// Input digital filter with divided sampling tick for the channel input
`timescale 1ns/1ps
`default_nettype none
module tcml_filt (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       en,
  input  wire logic [3:0] code,
  input  wire logic       din,
  output logic            dout
);

  // ---------------------------------------------------------------
  // Sampling tick
  // ---------------------------------------------------------------
  logic [4:0] div_reg;
  logic [3:0] run_reg;
  logic       out_reg;

  // A tick fires when the low bits of a free counter are all ones
  wire logic [2:0] sh      = tcml_pkg::FILT_SH[code];
  wire logic [3:0] n_need  = tcml_pkg::FILT_N[code];
  wire logic [4:0] mask    = 5'((6'h01 << sh) - 6'h01);
  wire logic       tick    = (div_reg & mask) == mask;   // [RULE23]
  wire logic [3:0] run_inc = run_reg + 4'h1;
  wire logic       done    = run_inc >= n_need;

  // Count samples that differ from the output; any agreeing sample restarts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 5'h00;
      run_reg <= 4'h0;
      out_reg <= 1'b0;
    end else if (ce) begin
      div_reg <= div_reg + 5'h01;
      if (en && tick) begin                 // [RULE16] [RULE19] [RULE20] [RULE21]
        if (din == out_reg) begin
          run_reg <= 4'h0;
        end else if (done) begin            // [RULE17] [RULE18]
          out_reg <= din;
          run_reg <= 4'h0;
        end else begin
          run_reg <= run_inc;
        end
      end
    end
  end

  assign dout = out_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_FILT_PASS: assert property (@(posedge clk) disable iff (!arst_n) // [RULE18]
    ce && en && code == 4'h0 |=> dout == $past(din))
    else $error("unfiltered input not passed in one cycle");
  AST_FILT_HOLD: assert property (@(posedge clk) disable iff (!arst_n) // [RULE16]
    !en |=> $stable(dout))
    else $error("filter output moved while channel is an output");
  AST_FILT_N2: assert property (@(posedge clk) disable iff (!arst_n) // [RULE17]
    ce && en && code == 4'h1 && din != dout && run_reg == 4'h0 |=> $stable(dout))
    else $error("filter accepted a single differing sample");
  CVR_FILT_SLOW: cover property (@(posedge clk) disable iff (!arst_n)
    en && code == 4'hF && $changed(dout));

endmodule : tcml_filt
`default_nettype wire

// [dv/tcml_pin_model.sv]
// Pin-side model: drives the channel input pin and watches the output pin
`timescale 1ns/1ps
`default_nettype none
module tcml_pin_model (
  input  wire logic clk,
  input  wire logic level,
  input  wire logic out_pin,
  output logic      in_pin,
  output logic      out_seen
);
  // Pin moves just after the edge, as a slow external source would
  always_ff @(posedge clk) begin
    in_pin   <= level;
    out_seen <= out_pin;
  end
endmodule : tcml_pin_model
`default_nettype wire

// [dv/tb_timer_channel_mode_logic.sv]
// Bench: register tasks and channel scenarios for the channel mode logic
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_mode_logic;
  logic        CLK, ARST_N = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
  logic        rready = 1'b0, down = 1'b0, upd = 1'b0, trig = 1'b0, lvl = 1'b0, ce = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, v;
  logic [15:0] cnt = 16'h0000;
  logic [1:0]  r;
  wire  logic  awrdy, wrdy, bvalid, arrdy, rvalid, cref, cpin, filt, pin_in, seen;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  int          n_mismatch = 0, checks = 0;
  // Mode word, trigger-instead-of-match flag (bit 1), expected reference (bit 0)
  logic [19:0] steps [0:10] = '{20'h10001,
    20'h00001, 20'h20000,
    20'h10002, 20'h18003,
    20'h30000, 20'h30001,
    20'h40000, 20'h50001,
    20'h60001, 20'h70000};

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  tcml_top uut (.CLK(CLK), .ARST_N(ARST_N), .CE(ce), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .COUNT_VALUE(cnt), .COUNT_DOWN(down), .UPDATE_EVENT(upd),
    .TRIG_EDGE(trig), .TIMER_INPUT_B(pin_in), .CMP_REFERENCE(cref),
    .CMP_OUTPUT_PIN(cpin), .FILTERED_INPUT_B(filt));

  tcml_pin_model pins (.clk(CLK), .level(lvl), .out_pin(cpin), .in_pin(pin_in),
    .out_seen(seen));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Readies are sampled mid-cycle, where nothing the bench drives is moving
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, da, dw;
    @(posedge CLK);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw)) begin
      @(negedge CLK);
      ta = !da && awrdy;
      tw = !dw && wrdy;
      @(posedge CLK);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      da |= ta;
      dw |= tw;
    end
    do @(negedge CLK); while (!bvalid);
    r = bresp;
    @(posedge CLK);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge CLK);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge CLK);
      t = arrdy;
      @(posedge CLK);
    end while (!t);
    arv <= 1'b0;
    do @(negedge CLK); while (!rvalid);
    v = rdata;
    r = rresp;
    @(posedge CLK);
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, v);
  endtask : rc

  // Three edges cover sampling, reference flop and the pin model
  task automatic settle;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
  endtask : settle

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (30000) @(posedge CLK);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge CLK);
    ARST_N <= 1'b1;
    rc(tcml_pkg::OFS_MODE, 32'h0, "mode reset");
    rd(8'h20);
    chk("unmapped resp", {30'h0, tcml_pkg::RESP_SLV}, {30'h0, r});
    wr(8'h20, 32'h1);
    chk("unmapped bresp", {30'h0, tcml_pkg::RESP_SLV}, {30'h0, r});
    wr(tcml_pkg::OFS_CMP, 32'h5);
    rc(tcml_pkg::OFS_SHADOW, 32'h5, "shadow direct");
    wr(tcml_pkg::OFS_CTRL, 32'h3); // Inverted pin, one-pulse kept for PWM
    foreach (steps[i]) begin
      wr(tcml_pkg::OFS_MODE, {16'h0, steps[i][19:4]});
      @(posedge CLK);
      if (steps[i][1]) trig <= 1'b1;
      else cnt <= 16'h0005;
      @(posedge CLK);
      trig <= 1'b0;
      cnt  <= 16'h0000;
      settle();
      chk("ref and pin", {steps[i][0], ~steps[i][0]}, {cref, seen});
    end
    @(posedge CLK);
    down <= 1'b1;
    cnt  <= 16'h0009;
    settle();
    chk("pwm2 down above", 32'h1, cref);
    @(posedge CLK);
    cnt <= 16'h0003;
    settle();
    chk("pwm2 down below", 32'h0, cref);
    rc(tcml_pkg::OFS_STAT, 32'h4, "status");
    // Enable low must freeze the reference even though the compare moved
    @(posedge CLK);
    ce  <= 1'b0;
    cnt <= 16'h0009;
    settle();
    chk("ref frozen by enable", 32'h0, cref);
    @(posedge CLK);
    ce <= 1'b1;
    settle();
    chk("ref after enable", 32'h1, cref);
    @(posedge CLK);
    cnt <= 16'h0003;
    settle();
    chk("ref back low", 32'h0, cref);
    wr(tcml_pkg::OFS_MODE, 32'h0400);
    wr(tcml_pkg::OFS_CMP, 32'h9);
    rc(tcml_pkg::OFS_SHADOW, 32'h5, "shadow before update");
    @(posedge CLK);
    upd <= 1'b1;
    @(posedge CLK);
    upd <= 1'b0;
    rc(tcml_pkg::OFS_SHADOW, 32'h9, "shadow after update");
    rc(tcml_pkg::OFS_CMP, 32'h9, "buffer read");
    wr(tcml_pkg::OFS_MODE, 32'h5100);
    settle();
    chk("ref held as input", 32'h0, cref);
    @(posedge CLK);
    lvl <= 1'b1;
    repeat (8) @(posedge CLK);
    @(negedge CLK);
    chk("filter early", 32'h0, filt);
    repeat (30) @(posedge CLK);
    @(negedge CLK);
    chk("filter late", 32'h1, filt);
    wr(tcml_pkg::OFS_MODE, 32'h0100);
    @(posedge CLK);
    lvl <= 1'b0;
    repeat (5) @(posedge CLK);
    @(negedge CLK);
    chk("filter none", 32'h0, filt);
    wr(tcml_pkg::OFS_MODE, 32'h1100);
    @(posedge CLK);
    lvl <= 1'b1;
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    chk("filter two early", 32'h0, filt);
    @(posedge CLK);
    @(negedge CLK);
    chk("filter two late", 32'h1, filt);
    wrap_up();
  end
endmodule : tb_timer_channel_mode_logic
`default_nettype wire
